// ### verilog/ppi_defines.svh
// register offsets, field positions, reset values and widths for the
// pixel input stage; assumes 8-bit wishbone byte addresses
`ifndef PPI_DEFINES_SVH
`define PPI_DEFINES_SVH

// =====================================================================
// register byte offsets
`define PPI_OFF_WADDR   8'h00
`define PPI_OFF_PALDATA 8'h04
`define PPI_OFF_CTRL    8'h08
`define PPI_OFF_MASK    8'h0C
`define PPI_OFF_STATUS  8'h10

// =====================================================================
// field positions
`define PPI_CTRL_OVL_BIT    0
`define PPI_CTRL_ANYTIME_BIT 1
`define PPI_ST_EMPTY_BIT    0
`define PPI_ST_FULL_BIT     1
`define PPI_ST_BLANK_BIT    2
`define PPI_ST_SYNC_BIT     3
`define PPI_ST_SETUP_BIT    4
`define PPI_ST_LEVEL_LSB    8

// =====================================================================
// reset values and sizes
`define PPI_MASK_RST    8'hFF
`define PPI_CTRL_RST    2'h0
`define PPI_WADDR_RST   8'h00
`define PPI_PAL_DEPTH   256
`define PPI_OVL_DEPTH   16
`define PPI_FIFO_DEPTH  8

`endif

// ### verilog/ppi_pkg.sv
// types shared by the pixel input stage and its write buffer;
// widths follow the constants header
package ppi_pkg;

   // =====================================================================
   // one 24-bit colour word, red in the top byte
   typedef struct packed {
      logic [7:0] red;
      logic [7:0] grn;
      logic [7:0] blu;
   } ppi_color_s;

   // one buffered colour update on its way to the lookup tables
   typedef struct packed {
      logic       ovl;
      logic [7:0] addr;
      ppi_color_s color;
   } ppi_entry_s;

endpackage

// ### verilog/ppi_fifo_if.sv
// carrier between the register side and the write buffer;
// both ends share clk_sys
`timescale 1ns/1ps

// =====================================================================
interface ppi_fifo_if #(parameter int W = 33);
   logic         in_valid;
   logic         in_ready;
   logic [W-1:0] in_data;
   logic         out_valid;
   logic         out_ready;
   logic [W-1:0] out_data;

   modport fifo (input in_valid, in_data, out_ready,
                 output in_ready, out_valid, out_data);
   modport user (output in_valid, in_data, out_ready,
                 input in_ready, out_valid, out_data);
endinterface

// ### verilog/ppi_fifo.sv
// synchronous buffer with valid/ready on both sides;
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps

// =====================================================================
module ppi_fifo #(
   parameter int W     = 33,
   parameter int DEPTH = 8
) (
   input  wire logic  clk_sys, // system clock
   input  wire logic  sys_rst, // async reset, active high
   ppi_fifo_if.fifo   bus      // push and pop sides
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0]   cnt_q;
   wire           push;
   wire           pop;

   // honest flags straight from the occupancy count
   assign bus.in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign bus.out_valid = (cnt_q != '0);
   assign bus.out_data  = mem[rp_q];
   assign push          = bus.in_valid & bus.in_ready;
   assign pop           = bus.out_valid & bus.out_ready;

   // storage has no reset; only the pointers and the count need a defined value
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wp_q] <= bus.in_data;
      end
   end

   // pointers wrap as the depth is a power of two
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop) rp_q <= rp_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ### verilog/ppi_pixel_stage.sv
// pixel-side front end of a colour lookup converter: captures the
// pixel, overlay, sync and blank inputs, looks up colour and drives
// per-channel converter codes plus current-source enables.
// assumes pixel inputs come from logic on clk_sys (the pixel clock)
// and registers are reached over classic wishbone.
`timescale 1ns/1ps
`include "ppi_defines.svh"

// =====================================================================
// Notes on behaviour
// [RL1] pixel, overlay, sync_n and blank_n are captured together each edge.
// [RL2] a captured blank_n of zero forces all colour codes to blanking level.
// [RL3] while blank_n is zero the pixel and overlay inputs are disregarded.
// [RL4] setup low picks a 0 IRE pedestal and setup high a 7.5 IRE pedestal.
// [RL5] a captured sync_n of zero turns off the 40 IRE sync current.
// [RL6] sync only removes its own current and overrides no other input.
// [RL7] the timing logic asserts sync_n only while blank_n is asserted.
// [RL8] the 8-bit pixel index, bit 0 lowest, picks one of 256 entries.
// [RL9] a nonzero overlay select takes its overlay colour, pixel ignored.
// [RL10] without sync blank, black and sync give no current; sync adds one.
// [RL11] code FF is white, 00 black, linear between, ignored when blanked.
// [RL12] the captured pixel index is ANDed with the pixel mask before lookup.
// [RL13] overlay select zero uses the palette, 1 to 15 pick overlays 1 to 15.
// [RL14] the chosen entry is 24 bits, split into red, green and blue codes.
// [RL15] codes and current enables are registered one clock after capture.
// [RL16] unused inputs read as zero, so a spare overlay bus keeps the palette.
module ppi_pixel_stage (
   input  wire logic        clk_sys,        // pixel/system clock
   input  wire logic        sys_rst,        // async reset, active high
   input  wire logic        wb_cyc_i,       // wishbone cycle
   input  wire logic        wb_stb_i,       // wishbone strobe
   input  wire logic        wb_we_i,        // wishbone write enable
   input  wire logic [7:0]  wb_adr_i,       // wishbone byte address
   input  wire logic [3:0]  wb_sel_i,       // wishbone byte selects
   input  wire logic [31:0] wb_dat_i,       // wishbone write data
   output logic      [31:0] wb_dat_o,       // wishbone read data
   output logic             wb_ack_o,       // wishbone acknowledge
   input  wire logic [7:0]  pixel_index,    // pixel index from frame buffer
   input  wire logic [3:0]  overlay_select, // overlay select
   input  wire logic        sync_n,         // composite sync, active low
   input  wire logic        blank_n,        // composite blank, active low
   input  wire logic        setup_pin,      // pedestal select pin
   output logic      [7:0]  color_code_red, // red converter code
   output logic      [7:0]  color_code_grn, // green converter code
   output logic      [7:0]  color_code_blu, // blue converter code
   output logic             sync_cur_en,    // 40 IRE sync source on
   output logic             blank_cur_en,   // video above blank level
   output logic             ped_cur_en      // 7.5 IRE pedestal on
);
   localparam int EW = $bits(ppi_pkg::ppi_entry_s);

   // every check below samples on the pixel clock and sleeps in reset
   default clocking cb_sys @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   // =====================================================================
   // lookup storage and captured pixel controls
   ppi_pkg::ppi_color_s pal_mem [`PPI_PAL_DEPTH];
   ppi_pkg::ppi_color_s ovl_mem [`PPI_OVL_DEPTH];

   logic [7:0] pix_q;
   logic [3:0] ovl_q;
   logic       sync_n_q;
   logic       blank_n_q;
   logic [2:0] setup_sync_q;
   logic       setup_q;

   // capture all pixel-side inputs on one edge so controls stay
   // aligned with colour data
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pix_q     <= 8'h00;
         ovl_q     <= 4'h0;
         sync_n_q  <= 1'b0;
         blank_n_q <= 1'b0;
      end else begin
         pix_q     <= pixel_index;    // [RL1]
         ovl_q     <= overlay_select; // [RL1]
         sync_n_q  <= sync_n;         // [RL1]
         blank_n_q <= blank_n;        // [RL1]
      end
   end

   // setup is a board-level pin: three flops, accept once the last
   // two agree so a glitch cannot flip the pedestal
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         setup_sync_q <= 3'h0;
         setup_q      <= 1'b0;
      end else begin
         setup_sync_q <= {setup_sync_q[1:0], setup_pin};
         if (setup_sync_q[1] == setup_sync_q[2]) begin
            setup_q <= setup_sync_q[2]; // [RL4]
         end
      end
   end

   // =====================================================================
   // register state
   logic [7:0] mask_q;
   logic [7:0] waddr_q;
   logic [1:0] ctrl_q;

   // =====================================================================
   // colour selection
   wire [7:0]           pix_masked;
   wire                 use_ovl;
   ppi_pkg::ppi_color_s lut_color;
   ppi_pkg::ppi_color_s sel_color;

   // mask before lookup; overlay zero means the palette, and an
   // unconnected overlay bus therefore keeps the palette path
   assign pix_masked = pix_q & mask_q;                       // [RL12]
   assign use_ovl    = (ovl_q != 4'h0);                      // [RL13] [RL16]
   assign lut_color  = use_ovl ? ovl_mem[ovl_q]              // [RL9]
                               : pal_mem[pix_masked];        // [RL8]
   // blanking discards the lookup, so pixel and overlay are ignored
   assign sel_color  = blank_n_q ? lut_color : '0;           // [RL2] [RL3]

   // codes pass straight to the converters: FF white, 00 black,
   // the converter itself is linear between them
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         color_code_red <= 8'h00;
         color_code_grn <= 8'h00;
         color_code_blu <= 8'h00;
      end else begin
         color_code_red <= sel_color.red; // [RL14] [RL11] [RL15]
         color_code_grn <= sel_color.grn; // [RL14] [RL11] [RL15]
         color_code_blu <= sel_color.blu; // [RL14] [RL11] [RL15]
      end
   end

   // current-source enables ride in the same stage as the codes;
   // sync only gates its own source and touches nothing else
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         sync_cur_en  <= 1'b0;
         blank_cur_en <= 1'b0;
         ped_cur_en   <= 1'b0;
      end else begin
         sync_cur_en  <= sync_n_q;             // [RL5] [RL6] [RL10]
         blank_cur_en <= blank_n_q;            // [RL2] [RL15]
         ped_cur_en   <= blank_n_q & setup_q;  // [RL4] [RL10]
      end
   end

   // =====================================================================
   // write buffer: palette updates queue here and drain into the
   // tables during blanking, so frequent updates cause no tearing
   ppi_fifo_if #(.W(EW)) wq ();

   ppi_fifo #(
      .W     (EW),
      .DEPTH (`PPI_FIFO_DEPTH)
   ) u_wq (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .bus     (wq.fifo)
   );

   ppi_pkg::ppi_entry_s drain_entry;
   wire                 drain_ok;
   wire                 drain;

   // draining waits for blanking unless software allows any time;
   // a full buffer then stalls the bus write below
   assign drain_ok     = ~blank_n_q | ctrl_q[`PPI_CTRL_ANYTIME_BIT];
   assign wq.out_ready = drain_ok;
   assign drain        = wq.out_valid & drain_ok;
   assign drain_entry  = ppi_pkg::ppi_entry_s'(wq.out_data);

   // tables carry no reset; software loads them after power-up
   always_ff @(posedge clk_sys) begin
      if (drain) begin
         if (drain_entry.ovl) begin
            ovl_mem[drain_entry.addr[3:0]] <= drain_entry.color;
         end else begin
            pal_mem[drain_entry.addr] <= drain_entry.color;
         end
      end
   end

   // =====================================================================
   // wishbone decode
   wire        req;
   wire [7:0]  reg_off;
   wire        hit_waddr;
   wire        hit_pal;
   wire        hit_ctrl;
   wire        hit_mask;
   wire        hit_stat;
   wire        pal_wr;
   wire        ack_d;
   wire        wr_en;
   wire [31:0] bmask;
   wire [31:0] wdat;
   wire [3:0]  level;
   logic [3:0] level_q;

   assign req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign reg_off   = {wb_adr_i[7:2], 2'b00};
   assign hit_waddr = (reg_off == `PPI_OFF_WADDR);
   assign hit_pal   = (reg_off == `PPI_OFF_PALDATA);
   assign hit_ctrl  = (reg_off == `PPI_OFF_CTRL);
   assign hit_mask  = (reg_off == `PPI_OFF_MASK);
   assign hit_stat  = (reg_off == `PPI_OFF_STATUS);
   assign pal_wr    = req & wb_we_i & hit_pal;
   // a palette write holds off its ack while the buffer is full
   assign ack_d     = req & (~pal_wr | wq.in_ready);
   assign wr_en     = ack_d & wb_we_i;
   assign bmask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wdat      = wb_dat_i & bmask;
   assign level     = level_q;

   // palette write pushes one whole entry; unselected lanes give zero
   assign wq.in_valid = pal_wr;
   assign wq.in_data  = {ctrl_q[`PPI_CTRL_OVL_BIT], waddr_q, wdat[23:0]};

   // occupancy mirrored here so status never reaches inside the buffer
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         level_q <= 4'h0;
      end else begin
         level_q <= level_q + 4'(wq.in_valid & wq.in_ready) - 4'(drain);
      end
   end

   // writable registers; the write address steps after each push
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         mask_q  <= `PPI_MASK_RST;
         waddr_q <= `PPI_WADDR_RST;
         ctrl_q  <= `PPI_CTRL_RST;
      end else if (wr_en) begin
         if (hit_mask && wb_sel_i[0]) mask_q <= wb_dat_i[7:0];
         if (hit_ctrl && wb_sel_i[0]) ctrl_q <= wb_dat_i[1:0];
         if (hit_waddr && wb_sel_i[0]) waddr_q <= wb_dat_i[7:0];
         if (hit_pal) waddr_q <= waddr_q + 8'h01;
      end
   end

   // read mux; unmapped offsets answer with zero
   logic [31:0] rdat;
   always_comb begin
      rdat = 32'h0000_0000;
      if (hit_waddr) rdat[7:0] = waddr_q;
      if (hit_ctrl) rdat[1:0] = ctrl_q;
      if (hit_mask) rdat[7:0] = mask_q;
      if (hit_pal) rdat[23:0] = ctrl_q[`PPI_CTRL_OVL_BIT]
                               ? ovl_mem[waddr_q[3:0]] : pal_mem[waddr_q];
      if (hit_stat) begin
         rdat[`PPI_ST_EMPTY_BIT] = ~wq.out_valid;
         rdat[`PPI_ST_FULL_BIT]  = ~wq.in_ready;
         rdat[`PPI_ST_BLANK_BIT] = blank_n_q;
         rdat[`PPI_ST_SYNC_BIT]  = sync_n_q;
         rdat[`PPI_ST_SETUP_BIT] = setup_q;
         rdat[`PPI_ST_LEVEL_LSB +: 4] = level;
      end
   end

   // single-cycle registered answer, dropped the cycle after
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= ack_d;
         wb_dat_o <= ack_d ? rdat : 32'h0000_0000;
      end
   end

   // =====================================================================
   // checks beside the pixel path; the $past guards skip the edges around
   // reset release, where the capture stage was still being cleared
   wire [23:0] code_word;

   assign code_word = {color_code_red, color_code_grn, color_code_blu};

   sequence s_blank_run;
      !blank_n_q ##1 !blank_n_q;
   endsequence

   sequence s_video_pix;
      blank_n_q && ovl_q == 4'h0;
   endsequence

   sequence s_same_ovl;
      blank_n_q && ovl_q != 4'h0 ##1 blank_n_q && $stable(ovl_q);
   endsequence

   AST_CAPTURE: assert property ( // [RL1]
      !$past(sys_rst) |-> {pix_q, ovl_q, sync_n_q, blank_n_q} ==
      $past({pixel_index, overlay_select, sync_n, blank_n}))
      else $error("pixel inputs not captured together");

   AST_BLANK_FORCE: assert property ( // [RL2]
      !blank_n_q |=> code_word == 24'h00_0000 && !blank_cur_en
      && !ped_cur_en)
      else $error("blank did not force blanking level");

   AST_BLANK_IGNORE: assert property ( // [RL3]
      s_blank_run |=> $stable(code_word))
      else $error("pixel or overlay leaked through blanking");

   AST_PEDESTAL: assert property ( // [RL4]
      ped_cur_en == $past(blank_n_q & setup_q))
      else $error("pedestal enable wrong");

   AST_PED_ON: assert property ( // [RL10]
      (blank_n_q && setup_q) |=> ped_cur_en && blank_cur_en)
      else $error("pedestal missing in active video");

   AST_SYNC_OFF: assert property ( // [RL5]
      !sync_n_q |=> !sync_cur_en)
      else $error("sync current not switched off");

   AST_SYNC_ON: assert property ( // [RL10]
      sync_n_q |=> sync_cur_en)
      else $error("sync current missing outside sync");

   AST_SYNC_NO_OVR: assert property ( // [RL6]
      (!sync_n_q && blank_n_q) |=> code_word == $past(lut_color)
      && blank_cur_en)
      else $error("sync overrode colour data");

   AST_PALETTE: assert property ( // [RL8]
      s_video_pix |=> code_word == $past(pal_mem[pix_q & mask_q]))
      else $error("palette lookup mismatch");

   AST_MASK_GATE: assert property ( // [RL12]
      (blank_n_q && ovl_q == 4'h0 && (pix_q & ~mask_q) != 8'h00) |=>
      code_word == $past(pal_mem[pix_q & mask_q]))
      else $error("masked index bits reached the lookup");

   AST_OVERLAY: assert property ( // [RL9]
      (blank_n_q && ovl_q != 4'h0) |=> code_word == $past(ovl_mem[ovl_q]))
      else $error("overlay lookup mismatch");

   AST_OVL_STEADY: assert property ( // [RL13]
      s_same_ovl |=> $stable(code_word))
      else $error("overlay colour followed the pixel index");

   AST_VIDEO_ON: assert property ( // [RL15]
      blank_n_q |=> blank_cur_en)
      else $error("video enable missing");

   AST_LATENCY: assert property ( // [RL15]
      (!$past(sys_rst) && blank_n && sync_n) ##1 1'b1 |=>
      (blank_cur_en && sync_cur_en))
      else $error("enables not two edges after pin");
endmodule

// ### tb/ppi_pix_src.sv
// model of the frame buffer and video timing logic feeding the stage
// assumes it shares clk_sys and changes its pins just after each edge
`timescale 1ns/1ps

// =====================================================================
module ppi_pix_src (
   input  wire logic       clk_sys,        // pixel clock
   input  wire logic [1:0] mode,           // 0 hold, 1 pal, 2 ovl, 3 bad
   input  wire logic       blank_low,      // force a blanking interval
   output logic      [7:0] pixel_index,    // pixel index
   output logic      [3:0] overlay_select, // overlay select
   output logic            sync_n,         // sync, active low
   output logic            blank_n         // blank, active low
);
   logic [3:0] roll;

   initial begin
      pixel_index = 8'h00;
      overlay_select = 4'h0;
      sync_n = 1'b1;
      blank_n = 1'b1;
   end

   // new pixel every edge outside mode 0 hold; mode 3 is the only one allowed to misuse sync
   always @(posedge clk_sys) begin
      roll = 4'($urandom);
      if (mode == 2'h0) begin
         blank_n <= ~blank_low;
         sync_n <= 1'b1;
      end else begin
         pixel_index <= 8'($urandom);
         overlay_select <= (mode == 2'h1) ? 4'h0 : 4'($urandom);
         blank_n <= ~blank_low & (roll > 4'h3);
         // outside mode 3, sync only inside blanking, since roll<2 implies blank
         sync_n <= (mode == 2'h3) ? roll[3] : (roll > 4'h1);
      end
   end
endmodule

// ### tb/tb_top.sv
// self-checking bench for the pixel input stage
// assumes one clock; registers over classic wishbone, pixels from a model
`timescale 1ns/1ps
`include "ppi_defines.svh"

// =====================================================================
module tb_top;
   logic clk_sys, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, d;
   logic [7:0]  pixel_index, color_code_red, color_code_grn;
   logic [7:0]  color_code_blu, mask_m;
   logic [3:0]  overlay_select;
   logic        sync_n, blank_n, setup_pin, blank_low, chk_on;
   logic        sync_cur_en, blank_cur_en, ped_cur_en;
   logic [1:0]  mode;
   logic [26:0] e_old, e_new;
   logic [23:0] pal_m [256];
   logic [23:0] ovl_m [16];
   int fails, tests_run, cyc_cnt, t0;
   int unsigned seed_v;

   ppi_pixel_stage ppi_pixel_stage_inst (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .pixel_index(pixel_index), .overlay_select(overlay_select),
      .sync_n(sync_n), .blank_n(blank_n), .setup_pin(setup_pin),
      .color_code_red(color_code_red), .color_code_grn(color_code_grn),
      .color_code_blu(color_code_blu), .sync_cur_en(sync_cur_en),
      .blank_cur_en(blank_cur_en), .ped_cur_en(ped_cur_en));

   ppi_pix_src ppi_pix_src_inst (.clk_sys(clk_sys), .mode(mode),
      .blank_low(blank_low), .pixel_index(pixel_index),
      .overlay_select(overlay_select), .sync_n(sync_n), .blank_n(blank_n));

   // =====================================================================
   // 20 MHz clock and cycle count
   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) cyc_cnt <= cyc_cnt + 1;

   task automatic finish_test();
      $display("checks %0d errors %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // one classic cycle; no latency assumed, only a bounded wait for ack
   task automatic wb_cycle(logic we, logic [7:0] adr, logic [31:0] din,
                           output logic [31:0] dout);
      int n;
      n = 0;
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= din;
      do begin
         @(posedge clk_sys);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 400);
      dout = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 400) begin
         fails++;
         $display("BAD wb_ack expected 1 seen none");
         finish_test();
      end
   endtask

   task automatic wr(logic [7:0] adr, logic [31:0] din);
      logic [31:0] x;
      wb_cycle(1'b1, adr, din, x);
   endtask

   task automatic wait_empty();
      int n;
      for (n = 0; n < 60; n++) begin
         wb_cycle(1'b0, `PPI_OFF_STATUS, 32'h0, d);
         if (d[`PPI_ST_EMPTY_BIT] === 1'b1) break;
      end
      check("empty", {31'h0, d[`PPI_ST_EMPTY_BIT]}, 32'h1);
      if (d[`PPI_ST_EMPTY_BIT] !== 1'b1) finish_test();
   endtask

   // =====================================================================
   // reference: outputs follow the pins two edges later
   function automatic logic [26:0] expect_px(logic [7:0] p, logic [3:0] o,
                                             logic s, logic b);
      logic [23:0] c;
      c = 24'h0;
      if (b) c = (o != 4'h0) ? ovl_m[o] : pal_m[p & mask_m];
      return {c, s, b, b & setup_pin};
   endfunction

   always @(posedge clk_sys) begin
      e_old <= e_new;
      e_new <= expect_px(pixel_index, overlay_select, sync_n, blank_n);
   end

   // one comparison per output, so a failure names its channel
   task automatic cmp_outputs();
      check("red", 32'(color_code_red), 32'(e_old[26:19]));
      check("grn", 32'(color_code_grn), 32'(e_old[18:11]));
      check("blu", 32'(color_code_blu), 32'(e_old[10:3]));
      check("sync_en", 32'(sync_cur_en), 32'(e_old[2]));
      check("video_en", 32'(blank_cur_en), 32'(e_old[1]));
      check("ped_en", 32'(ped_cur_en), 32'(e_old[0]));
   endtask

   always @(negedge clk_sys) begin
      if (chk_on) cmp_outputs();
   end

   task automatic run_px(logic [1:0] m, int n);
      mode <= m;
      repeat (3) @(posedge clk_sys);
      chk_on = 1'b1;
      repeat (n) @(posedge clk_sys);
      chk_on = 1'b0;
      mode <= 2'h0;
   endtask

   // =====================================================================
   initial begin
      clk_sys = 0;
      sys_rst = 1;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
      wb_sel_i = 4'hF;
      {setup_pin, blank_low, chk_on, mode, e_old, e_new} = '0;
      blank_low = 1'b1; // blank until the tables hold known colours
      {fails, tests_run, cyc_cnt} = '0;
      mask_m = 8'hFF;
      seed_v = $urandom(64733);
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      // reset values, then an unmapped place
      wb_cycle(1'b0, `PPI_OFF_MASK, 32'h0, d);
      check("mask_rst", d, 32'h000000FF);
      wb_cycle(1'b0, `PPI_OFF_WADDR, 32'h0, d);
      check("waddr_rst", d, 32'h0);
      wr(8'h14, 32'hFFFFFFFF);
      wb_cycle(1'b0, 8'h14, 32'h0, d);
      check("unmapped", d, 32'h0);
      // load palette and overlays with the buffer draining at any time
      wr(`PPI_OFF_CTRL, 32'h2);
      wr(`PPI_OFF_WADDR, 32'h0);
      for (int i = 0; i < 256; i++) begin
         pal_m[i] = 24'($urandom);
         wr(`PPI_OFF_PALDATA, {8'h0, pal_m[i]});
      end
      wr(`PPI_OFF_CTRL, 32'h3);
      wr(`PPI_OFF_WADDR, 32'h1);
      for (int i = 1; i < 16; i++) begin
         ovl_m[i] = 24'($urandom);
         wr(`PPI_OFF_PALDATA, {8'h0, ovl_m[i]});
      end
      wait_empty();
      wr(`PPI_OFF_CTRL, 32'h0);
      for (int k = 0; k < 4; k++) begin
         t0 = $urandom_range(255);
         wr(`PPI_OFF_WADDR, 32'(t0));
         wb_cycle(1'b0, `PPI_OFF_PALDATA, 32'h0, d);
         check("pal_rd", d, {8'h0, pal_m[t0]});
      end
      // pixel traffic: palette, overlays, pedestal, sync misuse, mask
      blank_low <= 1'b0;
      run_px(2'h1, 300);
      run_px(2'h2, 300);
      setup_pin <= 1'b1;
      repeat (8) @(posedge clk_sys);
      run_px(2'h2, 200);
      run_px(2'h3, 200);
      wr(`PPI_OFF_MASK, 32'h0000000F);
      mask_m = 8'h0F;
      run_px(2'h1, 200);
      // fill the buffer in active video until it refuses
      wr(`PPI_OFF_WADDR, 32'h10);
      for (int i = 16; i < 24; i++) begin
         pal_m[i] = 24'($urandom);
         wr(`PPI_OFF_PALDATA, {8'h0, pal_m[i]});
      end
      wb_cycle(1'b0, `PPI_OFF_STATUS, 32'h0, d);
      check("full", {28'h0, d[11:8]}, 32'h8);
      pal_m[24] = 24'($urandom);
      t0 = cyc_cnt;
      fork
         wr(`PPI_OFF_PALDATA, {8'h0, pal_m[24]});
         begin
            repeat (30) @(posedge clk_sys);
            blank_low <= 1'b1;
         end
      join
      check("stall", 32'(cyc_cnt - t0 >= 30), 32'h1);
      wait_empty();
      blank_low <= 1'b0;
      run_px(2'h2, 300);
      finish_test();
   end
endmodule
